/* qpc_consts.svh */
`ifndef QPC_CONSTS_SVH
`define QPC_CONSTS_SVH

// Register byte offsets
`define QPC_OFF_CONFIG 12'h000
`define QPC_OFF_TRIGGER 12'h004
`define QPC_OFF_CONST_A 12'h008
`define QPC_OFF_CONST_B 12'h00C
`define QPC_OFF_COUNT 12'h010
`define QPC_OFF_STATUS 12'h014
`define QPC_OFF_MASK 12'h018

// Control field positions
`define QPC_MODE_LO 0
`define QPC_POL_BIT 3
`define QPC_XSEL_LO 4
`define QPC_BEN_BIT 6
`define QPC_IDX_LO 7
`define QPC_ISEL_LO 10
`define QPC_FILT_BIT 13
`define QPC_IEN_BIT 15
`define QPC_CFG_WMASK 16'hAFFF
`define QPC_CFG_RESET 16'h0000

// Status bits
`define QPC_ST_IRQ 0
`define QPC_ST_INDEX 1
`define QPC_ST_MATCH 2
`define QPC_ST_WIDTH 3

// Timing
`define QPC_CLK_MHZ 40
`define QPC_FILT_NS 2500
`define QPC_FILT_CYC ((`QPC_FILT_NS * `QPC_CLK_MHZ + 999) / 1000 + 1)

`endif

/* qpc_encoder_model.sv */
`timescale 1ns/10ps
module qpc_encoder_model (
    // Clock
    input wire logic pclk,
    // Encoder lines
    output qpc_pkg::qpc_enc_s enc
);
    import qpc_pkg::*;
    logic [1:0] ph = 2'h0;
    logic idx = 1'b0;
    // Gray order: going up, A changes a quarter cycle before B
    assign enc = '{a: ^ph, b: ph[1], idx: idx};
    // Hold sets how slowly the shaft turns; levels change only after an edge
    task automatic step(input int dir, input int hold);
        @(posedge pclk);
        ph <= ph + dir[1:0];
        repeat (hold) @(posedge pclk);
    endtask
    task automatic set_idx(input logic v);
        @(posedge pclk);
        idx <= v;
        repeat (10) @(posedge pclk);
    endtask
endmodule

/* qpc_pkg.sv */
package qpc_pkg;
    typedef enum logic [2:0] {
        QPC_MODE_OFF = 3'h0,
        QPC_MODE_QUAD = 3'h1
    } qpc_mode_e;

    typedef struct packed {
        logic ien;
        logic unused14;
        logic filt;
        logic unused12;
        logic [1:0] isel;
        logic [2:0] idx;
        logic ben;
        logic [1:0] xsel;
        logic pol;
        logic [2:0] mode;
    } qpc_cfg_s;

    typedef struct packed {
        logic a;
        logic b;
        logic idx;
    } qpc_enc_s;

    typedef enum {
        QPC_IDLE,
        QPC_RUN
    } qpc_state_e;
endpackage

/* qpc_top.sv */
// Notes on behaviour
// RL1: Mode field bits 2..0 equal to 001 selects quadrature position measurement.
// RL2: Bit 3 sets output polarity; 0 active low by default, 1 active high.
// RL3: Output rests high whenever the channel is not actively driving it.
// RL4: Bits 5..4 pick channel A decoding: off, X1, X2 or X4.
// RL5: Bit 6 enables channel B for decoding; off by default.
// RL6: Bits 9..7 choose index phase; codes 1..4 map A/B levels, others disable.
// RL7: Bits 11..10 pick interrupt: none, count equals A, index reload, index only.
// RL8: Bit 13 rejects A, B or index pulses of 2.5 us or shorter.
// RL9: Bits 12 and 14 ignore writes and read as zero.
// RL10: Interrupt raised only with bit 15 set and a nonzero condition selected.
// RL11: Pending interrupt held until status bit cleared or bit 15 cleared.
// RL12: Condition still present after a clear raises the interrupt again.
// RL13: Count read-back location returns the live position count.
// RL14: Count rises when A leads B and falls when B leads A.
// RL15: X1 counts A rising up and falling down; X2 both A edges; X4 all edges.
// RL16: Counting starts only after a software trigger at offset 04H.
// RL17: Index reload loads the count with the constant B value.
// RL18: Count is 16 bits and wraps modulo 65536.
// RL19: Inputs synchronised before edge detection; one count update per clock.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "qpc_consts.svh"

module qpc_top #(
    parameter int FILT_CYC = `QPC_FILT_CYC
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Encoder
    input wire qpc_pkg::qpc_enc_s enc_in,
    // Outputs
    output logic chan_out,
    output logic irq
);
    import qpc_pkg::*;

    // The filter counter is eight bits wide, so longer windows cannot be served
    if (FILT_CYC < 2 || FILT_CYC > 255) begin : g_bad_filt
        $error("FILT_CYC out of range");
    end

    qpc_cfg_s cfg;
    logic [15:0] const_a;
    logic [15:0] const_b;
    logic [15:0] count;
    logic [`QPC_ST_WIDTH-1:0] status;
    logic [`QPC_ST_WIDTH-1:0] mask;
    qpc_state_e state;
    qpc_enc_s sync1;
    qpc_enc_s sync2;
    qpc_enc_s filt;
    qpc_enc_s prev;
    logic [2:0][7:0] fcnt;

    // APB decode
    wire acc = psel && penable && clk_en;
    wire wr = acc && pwrite;
    wire wr_cfg = wr && paddr == `QPC_OFF_CONFIG;
    wire wr_trig = wr && paddr == `QPC_OFF_TRIGGER;
    wire wr_ca = wr && paddr == `QPC_OFF_CONST_A;
    wire wr_cb = wr && paddr == `QPC_OFF_CONST_B;
    wire wr_st = wr && paddr == `QPC_OFF_STATUS;
    wire wr_mask = wr && paddr == `QPC_OFF_MASK;
    wire hit = paddr == `QPC_OFF_CONFIG || paddr == `QPC_OFF_TRIGGER || paddr == `QPC_OFF_CONST_A
        || paddr == `QPC_OFF_CONST_B || paddr == `QPC_OFF_COUNT || paddr == `QPC_OFF_STATUS
        || paddr == `QPC_OFF_MASK;
    wire [15:0] cfg_rd = cfg & `QPC_CFG_WMASK; // RL9

    wire quad = cfg.mode == QPC_MODE_QUAD; // RL1
    wire running = quad && state == QPC_RUN;

    // Filter: a level change must persist longer than the reject window; short pulses vanish
    generate
        for (genvar i = 0; i < 3; i++) begin : g_filt
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fcnt[i] <= 8'h00;
                    filt[i] <= 1'b0;
                end else if (clk_en) begin
                    if (!cfg.filt || sync2[i] == filt[i]) begin // RL8
                        fcnt[i] <= 8'h00;
                        filt[i] <= cfg.filt ? filt[i] : sync2[i];
                    end else if (fcnt[i] == 8'(FILT_CYC - 1)) begin // RL8
                        fcnt[i] <= 8'h00;
                        filt[i] <= sync2[i];
                    end else begin
                        fcnt[i] <= fcnt[i] + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // Edge decode
    wire a = filt.a;
    wire b = filt.b & cfg.ben; // RL5
    wire pa = prev.a;
    wire pb = prev.b & cfg.ben;
    wire a_rise = a && !pa;
    wire a_fall = !a && pa;
    wire b_edge = b != pb;
    // A leading B: at an A edge the new A differs from B
    wire a_dir = a != b; // RL14
    wire b_dir = a == b; // RL14
    logic step_up;
    logic step_dn;
    always_comb begin
        step_up = 1'b0;
        step_dn = 1'b0;
        case (cfg.xsel) // RL4
            2'h1: begin
                step_up = a_rise && a_dir; // RL15
                step_dn = a_fall && !a_dir;
            end
            2'h2: begin
                step_up = (a_rise || a_fall) && a_dir; // RL15
                step_dn = (a_rise || a_fall) && !a_dir;
            end
            2'h3: begin
                step_up = ((a_rise || a_fall) && a_dir) || (b_edge && b_dir); // RL15
                step_dn = ((a_rise || a_fall) && !a_dir) || (b_edge && !b_dir);
            end
            default: begin
                step_up = 1'b0;
                step_dn = 1'b0;
            end
        endcase
    end

    // Index phase match
    logic phase_ok;
    always_comb begin
        case (cfg.idx) // RL6
            3'h1: phase_ok = !a && b;
            3'h2: phase_ok = a && !b;
            3'h3: phase_ok = a && b;
            3'h4: phase_ok = !a && !b;
            default: phase_ok = 1'b0;
        endcase
    end
    wire index_ev = running && filt.idx && phase_ok;
    wire do_reload = index_ev && cfg.isel == 2'h2; // RL17
    wire match = running && count == const_a;
    wire cond = cfg.isel == 2'h1 ? match : (cfg.isel[1] ? index_ev : 1'b0); // RL7
    wire raise = cfg.ien && cond; // RL10 RL12
    wire [15:0] next_count = do_reload ? const_b
        : (step_up ? count + 16'h0001 : (step_dn ? count - 16'h0001 : count)); // RL18 RL19
    wire [`QPC_ST_WIDTH-1:0] ev = {match, index_ev, raise};
    wire [`QPC_ST_WIDTH-1:0] clr = wr_st ? pwdata[`QPC_ST_WIDTH-1:0] : '0;
    wire [`QPC_ST_WIDTH-1:0] next_status = ev | (status & ~clr);
    // Pending flag drops as soon as interrupt service is switched off
    wire [`QPC_ST_WIDTH-1:0] next_pend = {next_status[`QPC_ST_WIDTH-1:1], next_status[0] && cfg.ien}; // RL11

    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            `QPC_OFF_CONFIG: rd_mux = {16'h0000, cfg_rd};
            `QPC_OFF_CONST_A: rd_mux = {16'h0000, const_a};
            `QPC_OFF_CONST_B: rd_mux = {16'h0000, const_b};
            `QPC_OFF_COUNT: rd_mux = {16'h0000, count}; // RL13
            `QPC_OFF_STATUS: rd_mux = {29'h0, status};
            `QPC_OFF_MASK: rd_mux = {29'h0, mask};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `QPC_CFG_RESET;
            const_a <= 16'h0000;
            const_b <= 16'h0000;
            mask <= '0;
        end else if (clk_en) begin
            if (wr_cfg) cfg <= pwdata[15:0] & `QPC_CFG_WMASK; // RL9
            if (wr_ca) const_a <= pwdata[15:0];
            if (wr_cb) const_b <= pwdata[15:0];
            if (wr_mask) mask <= pwdata[`QPC_ST_WIDTH-1:0];
        end
    end

    // Setting and clearing in one cycle: the event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
        end else if (clk_en) begin
            status <= next_pend; // RL11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= QPC_IDLE;
        end else if (clk_en) begin
            case (state)
                QPC_IDLE: if (quad && wr_trig && pwdata[0]) state <= QPC_RUN; // RL16
                QPC_RUN: if (!quad) state <= QPC_IDLE;
                default: state <= QPC_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
            count <= 16'h0000;
        end else if (clk_en) begin
            sync1 <= enc_in; // RL19
            sync2 <= sync1;
            prev <= filt;
            if (running) count <= next_count;
        end
    end

    // Output drives active level on index while running, else rests high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_out <= 1'b1;
            irq <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            chan_out <= (running && index_ev) ? cfg.pol : 1'b1; // RL2 RL3
            irq <= |(next_pend & mask);
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
            pslverr <= psel && !penable && !hit;
        end
    end

    sequence s_trig;
        quad && wr_trig && pwdata[0] && state == QPC_IDLE && clk_en;
    endsequence
    trig_start_a: assert property (@(posedge pclk) disable iff (!presetn) // RL16
        s_trig |=> state == QPC_RUN) else $error("trigger did not start count");
    idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL16
        state == QPC_IDLE && clk_en |=> $stable(count)) else $error("count moved before trigger");
    reload_b_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
        do_reload && clk_en |=> count == $past(const_b)) else $error("index reload missed");
    step_one_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18
        running && !do_reload && clk_en && step_up |=> count == $past(count) + 16'h0001)
        else $error("up step wrong");
    cfg_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RL9
        cfg_rd[12] == 1'b0 && cfg_rd[14] == 1'b0) else $error("unused bits set");
    irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
        !cfg.ien && clk_en |=> !status[`QPC_ST_IRQ]) else $error("irq while disabled");
    irq_raise_a: assert property (@(posedge pclk) disable iff (!presetn) // RL12
        raise && clk_en |=> status[`QPC_ST_IRQ] ##1 1'b1) else $error("condition did not raise");
    out_rest_a: assert property (@(posedge pclk) disable iff (!presetn) // RL3
        !running ##1 !running |-> chan_out) else $error("output not resting high");
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && clk_en |=> pready) else $error("no ready after setup");

    // A counted cycle: running, no reload pending, clock enabled
    sequence s_move;
        running && !do_reload && clk_en;
    endsequence

    sequence s_filt_wait;
        cfg.filt && clk_en && sync2.a != filt.a && fcnt[2] != 8'(FILT_CYC - 1);
    endsequence

    sequence s_idx_off;
        cfg.idx == 3'h0 || cfg.idx > 3'h4;
    endsequence

    step_down_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18
        s_move ##0 (step_dn && !step_up) |=> count == $past(count) - 16'h0001)
        else $error("down step wrong");

    x1_fall_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL15
        s_move ##0 (cfg.xsel == 2'h1 && a_fall && a_dir) |=> $stable(count))
        else $error("x1 counted a forward fall");

    x1_rise_up_a: assert property (@(posedge pclk) disable iff (!presetn) // RL15
        s_move ##0 (cfg.xsel == 2'h1 && a_rise && a_dir) |=> count == $past(count) + 16'h0001)
        else $error("x1 missed a forward rise");

    xsel_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
        s_move ##0 (cfg.xsel == 2'h0) |=> $stable(count))
        else $error("count moved with channel A off");

    b_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
        s_move ##0 (!cfg.ben && !a_rise && !a_fall) |=> $stable(count))
        else $error("count moved on gated channel B");

    idx_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
        s_idx_off |-> !index_ev)
        else $error("index event with phase disabled");

    cond_none_a: assert property (@(posedge pclk) disable iff (!presetn) // RL7
        cfg.isel == 2'h0 |-> !raise)
        else $error("interrupt with no condition");

    idx_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // RL7
        index_ev && cfg.ien && cfg.isel[1] && clk_en |=> status[`QPC_ST_IRQ])
        else $error("index interrupt missed");

    filt_reject_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
        s_filt_wait |=> $stable(filt.a))
        else $error("short pulse passed the filter");

    irq_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RL11
        wr_st && pwdata[0] && !raise && clk_en |=> !status[`QPC_ST_IRQ])
        else $error("pending interrupt not cleared");

    out_active_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
        index_ev && clk_en |=> chan_out == $past(cfg.pol))
        else $error("output not at active level");

    sync_chain_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
        clk_en |=> sync2 == $past(sync1))
        else $error("synchroniser chain broken");

    apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !hit && clk_en |=> pslverr && pready)
        else $error("unmapped access not flagged");

    rd_count_a: assert property (@(posedge pclk) disable iff (!presetn) // RL13
        psel && !penable && !pwrite && paddr == `QPC_OFF_COUNT && clk_en |=> prdata[15:0] == $past(count))
        else $error("count read-back wrong");

    mode_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
        !quad |-> !running)
        else $error("running outside quadrature mode");
endmodule

/* tb.sv */
`timescale 1ns/10ps
`include "qpc_consts.svh"
module tb;
    import qpc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready, pslverr, chan_out, irq, err;
    logic saw_low = 1'b0;
    logic clk_en = 1'b1;
    qpc_enc_s enc_in;
    int mismatches = 0;
    int tests_run = 0;
    qpc_top #(.FILT_CYC(4)) i_qpc_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enc_in(enc_in), .chan_out(chan_out), .irq(irq));
    qpc_encoder_model i_qpc_encoder_model (.pclk(pclk), .enc(enc_in));
    initial forever #12.5 pclk = ~pclk;
    // The output stays low only while the index lasts, so catch it here
    always @(posedge pclk) if (chan_out === 1'b0) saw_low <= 1'b1;
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (3) @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        chk(q, exp, msg);
    endtask
    task automatic mv(input int dir, input int n);
        repeat (n) i_qpc_encoder_model.step(dir, 10);
    endtask
    task automatic t_regs;
        rd_chk(`QPC_OFF_CONFIG, 32'h0, "cfg reset");
        chk({31'h0, chan_out}, 32'h1, "idle out");
        wr(`QPC_OFF_CONFIG, 32'hFFFF);
        rd_chk(`QPC_OFF_CONFIG, 32'hAFFF, "cfg unused");
        apb(1'b0, 12'h01C, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        wr(`QPC_OFF_CONFIG, 32'h0);
        $display("t_regs done");
    endtask
    task automatic t_count;
        wr(`QPC_OFF_CONFIG, 32'h71);
        mv(1, 2);
        rd_chk(`QPC_OFF_COUNT, 32'h0, "no trigger");
        wr(`QPC_OFF_TRIGGER, 32'h1);
        mv(1, 4);
        rd_chk(`QPC_OFF_COUNT, 32'h4, "x4 up");
        mv(-1, 6);
        rd_chk(`QPC_OFF_COUNT, 32'hFFFE, "x4 wrap");
        wr(`QPC_OFF_CONFIG, 32'h61);
        mv(1, 4);
        rd_chk(`QPC_OFF_COUNT, 32'h0, "x2");
        wr(`QPC_OFF_CONFIG, 32'h51);
        mv(1, 4);
        rd_chk(`QPC_OFF_COUNT, 32'h1, "x1 up");
        mv(-1, 4);
        rd_chk(`QPC_OFF_COUNT, 32'h0, "x1 down");
        $display("t_count done");
    endtask
    task automatic t_irq;
        wr(`QPC_OFF_MASK, 32'h1);
        wr(`QPC_OFF_CONST_A, 32'h2);
        wr(`QPC_OFF_CONFIG, 32'h8071);
        mv(1, 2);
        chk({31'h0, irq}, 32'h0, "no cond");
        wr(`QPC_OFF_CONFIG, 32'h8471);
        chk({31'h0, irq}, 32'h1, "match");
        wr(`QPC_OFF_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0, "masked");
        wr(`QPC_OFF_MASK, 32'h1);
        mv(1, 1);
        chk({31'h0, irq}, 32'h1, "held");
        wr(`QPC_OFF_STATUS, 32'h7);
        chk({31'h0, irq}, 32'h0, "cleared");
        mv(-1, 1);
        wr(`QPC_OFF_STATUS, 32'h7);
        chk({31'h0, irq}, 32'h1, "level");
        wr(`QPC_OFF_CONFIG, 32'h0471);
        chk({31'h0, irq}, 32'h0, "ien off");
        $display("t_irq done");
    endtask
    task automatic t_index;
        wr(`QPC_OFF_CONST_B, 32'h1234);
        wr(`QPC_OFF_CONFIG, 32'h89F1);
        i_qpc_encoder_model.set_idx(1'b1);
        rd_chk(`QPC_OFF_COUNT, 32'h1234, "reload");
        chk({31'h0, irq}, 32'h1, "idx irq");
        chk({31'h0, saw_low}, 32'h1, "low pulse");
        i_qpc_encoder_model.set_idx(1'b0);
        wr(`QPC_OFF_STATUS, 32'h7);
        wr(`QPC_OFF_CONST_B, 32'h5555);
        wr(`QPC_OFF_CONFIG, 32'h8DF1);
        mv(1, 1);
        i_qpc_encoder_model.set_idx(1'b1);
        chk({31'h0, irq}, 32'h0, "wrong phase");
        mv(-1, 1);
        rd_chk(`QPC_OFF_COUNT, 32'h1234, "no reload");
        chk({31'h0, irq}, 32'h1, "idx only");
        $display("t_index done");
    endtask
    task automatic t_filt;
        wr(`QPC_OFF_CONFIG, 32'h2071);
        i_qpc_encoder_model.step(1, 2);
        i_qpc_encoder_model.step(-1, 10);
        rd_chk(`QPC_OFF_COUNT, 32'h1234, "glitch");
        mv(1, 1);
        rd_chk(`QPC_OFF_COUNT, 32'h1235, "filtered step");
        $display("t_filt done");
    endtask
    task automatic t_freeze;
        clk_en <= 1'b0;
        psel <= 1'b1;
        pwrite <= 1'b0;
        paddr <= `QPC_OFF_COUNT;
        repeat (3) @(posedge pclk);
        chk({31'h0, pready}, 32'h0, "frozen");
        psel <= 1'b0;
        clk_en <= 1'b1;
        @(posedge pclk);
        rd_chk(`QPC_OFF_COUNT, 32'h1235, "thawed");
        $display("t_freeze done");
    endtask
    task automatic wrap_up;
        $display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Whole run is some 570 cycles; allow over ten times that
    initial begin
        #200000;
        mismatches++;
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_count;
        t_irq;
        t_index;
        t_filt;
        t_freeze;
        wrap_up;
    end
endmodule
